// ### inc/acr_pkg.sv
`default_nettype none
package acr_pkg;
	// ====================================================================
	// register indices (word index; byte address is four times this)
	localparam logic [3:0] IDX_CLOCK = 4'h3;
	localparam logic [3:0] IDX_GAIN = 4'h4;
	localparam logic [3:0] IDX_SPARE = 4'h5;
	localparam logic [3:0] IDX_CFG = 4'h6;
	localparam logic [3:0] IDX_THR_UP = 4'h7;
	localparam logic [3:0] IDX_THR_LO = 4'h8;
	localparam int ADDR_W = 12;
	// ====================================================================
	// reset values
	localparam logic [15:0] RST_CLOCK = 16'h0F0E;
	localparam logic [15:0] RST_GAIN = 16'h0000;
	localparam logic [15:0] RST_SPARE = 16'h0000;
	localparam logic [15:0] RST_CFG = 16'h0600;
	localparam logic [15:0] RST_THR_UP = 16'h0000;
	localparam logic [15:0] RST_THR_LO = 16'h0000;
	// ====================================================================
	// writable bit masks
	localparam logic [15:0] WMASK_CLOCK = 16'h0FFF;
	localparam logic [15:0] WMASK_THR_LO = 16'hFF0F;
	// ====================================================================
	// field positions
	localparam int CLK_EN_LSB = 8;
	localparam int CLK_OSR_LSB = 2;
	localparam int CLK_PWR_LSB = 0;
	localparam int GAIN_STRIDE = 4;
	localparam int CFG_DLY_LSB = 9;
	localparam int CFG_CHOP_BIT = 8;
	localparam int CFG_ALL_BIT = 7;
	localparam int CFG_NUM_LSB = 4;
	localparam int CFG_LEN_LSB = 1;
	localparam int CFG_DET_BIT = 0;
	localparam int THR_LO_LSB = 8;
	localparam int THR_DCB_LSB = 0;
	// ====================================================================
	typedef enum logic [1:0] {
		ACR_PWR_VLOW = 2'h0,
		ACR_PWR_LOW = 2'h1,
		ACR_PWR_HIRES = 2'h2
	} acr_pwr_t;
	localparam logic [14:0] OSR_TOP = 15'h3F80;
endpackage
`default_nettype wire

// ### design/acr_regbank.sv
// Contract
// R1 - address 3 is clock/channel config, reset F0Eh
// R2 - bits 11:8 enable channels 3..0, reset to 1
// R3 - bits 4:2 pick oversampling 128..16256, reset 011b (1024)
// R4 - bits 1:0 power: 00 very-low, 01 low, 1x high-resolution
// R5 - address 4 is gain register, reset zero (unity gains)
// R6 - gain code 000..111 maps to gain 1..128
// R7 - gain codes at 14:12,10:8,6:4,2:0; bits 15,11,7,3 plain rw
// R8 - address 6 is chop/detect config, reset 600h
// R9 - bits 12:9 chop delay is 2^(code+1) modulator clocks, reset 0011b
// R10 - bit 8 enables global chop, reset 0
// R11 - bit 7 detect needs any (0) or all (1) channels
// R12 - bits 6:4 detect hit count 1..128, reset 000b
// R13 - address 5 spare rw word, resets zero, no effect
// R14 - bits 3:1 detect window length table; bit 0 detect enable
// R15 - threshold from upper 16-bit and lower 8-bit registers
// R16 - clock register bits 15:12 read zero, writes ignored
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module acr_regbank (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [acr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [3:0] chan_enable,
	output logic [14:0] oversampling_ratio,
	output logic [1:0] power_mode_sel,
	output logic [3:0][7:0] chan_gain,
	output logic chop_enable,
	output logic [16:0] chop_settle_cycles,
	output logic detect_mode_enable,
	output logic detect_all_channels,
	output logic [7:0] detect_hit_count,
	output logic [11:0] detect_window_length,
	output logic [23:0] detect_threshold,
	output logic [3:0] dc_block_sel
);
	import acr_pkg::*;

	// ====================================================================
	// state
	typedef struct packed {
		logic [15:0] clock_channel_config;
		logic [15:0] channel_gain_select;
		logic [15:0] spare_word;
		logic [15:0] chop_and_detect_config;
		logic [15:0] detect_threshold_upper;
		logic [15:0] detect_threshold_lower;
		logic [31:0] rdata;
		logic err;
	} acr_state_t;

	acr_state_t state_ff;
	acr_state_t nxt_state;

	// ====================================================================
	// helpers
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] strb,
		input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			v[15:8] = wd[15:8];
		end
		merge16 = (v & mask) | (old & ~mask);
	endfunction

	function automatic logic [7:0] pow2_8(input logic [2:0] code);
		pow2_8 = 8'h01 << code;
	endfunction

	function automatic logic [11:0] window_len(input logic [2:0] code);
		case (code)
			3'h0: window_len = 12'h080;
			3'h1: window_len = 12'h100;
			3'h2: window_len = 12'h200;
			3'h3: window_len = 12'h300;
			3'h4: window_len = 12'h500;
			3'h5: window_len = 12'h700;
			3'h6: window_len = 12'hA00;
			3'h7: window_len = 12'hE00;
			default: window_len = 12'h080;
		endcase
	endfunction

	logic access;
	logic mapped;
	logic [3:0] idx;
	logic [15:0] rword;

	assign access = psel && penable;
	assign idx = paddr[5:2];
	assign mapped = (paddr[1:0] == 2'h0)
		&& (paddr[ADDR_W-1:6] == '0)
		&& (idx >= IDX_CLOCK) && (idx <= IDX_THR_LO);

	// ====================================================================
	// read mux
	always_comb begin
		rword = 16'h0000;
		case (idx)
			IDX_CLOCK: rword = state_ff.clock_channel_config & WMASK_CLOCK; // R16
			IDX_GAIN: rword = state_ff.channel_gain_select; // R5
			IDX_SPARE: rword = state_ff.spare_word; // R13
			IDX_CFG: rword = state_ff.chop_and_detect_config; // R8
			IDX_THR_UP: rword = state_ff.detect_threshold_upper; // R15
			IDX_THR_LO: rword = state_ff.detect_threshold_lower & WMASK_THR_LO;
			default: rword = 16'h0000;
		endcase
	end

	// ====================================================================
	// next state
	// read word and error are captured in the setup cycle, so the
	// access cycle can answer from flip-flops with no wait state
	always_comb begin
		nxt_state = state_ff;
		nxt_state.err = 1'b0;
		nxt_state.rdata = 32'h0000_0000;
		if (psel && !penable) begin
			nxt_state.err = !mapped;
			if (mapped && !pwrite) begin
				nxt_state.rdata = {16'h0000, rword};
			end
		end
		if (access) begin
			if (mapped && pwrite) begin
				case (idx)
					IDX_CLOCK: nxt_state.clock_channel_config = merge16(
						state_ff.clock_channel_config, pwdata, pstrb,
						WMASK_CLOCK); // R1 R16
					IDX_GAIN: nxt_state.channel_gain_select = merge16(
						state_ff.channel_gain_select, pwdata, pstrb,
						16'hFFFF); // R7
					IDX_SPARE: nxt_state.spare_word = merge16(
						state_ff.spare_word, pwdata, pstrb, 16'hFFFF); // R13
					IDX_CFG: nxt_state.chop_and_detect_config = merge16(
						state_ff.chop_and_detect_config, pwdata, pstrb,
						16'hFFFF); // R8
					IDX_THR_UP: nxt_state.detect_threshold_upper = merge16(
						state_ff.detect_threshold_upper, pwdata, pstrb,
						16'hFFFF); // R15
					IDX_THR_LO: nxt_state.detect_threshold_lower = merge16(
						state_ff.detect_threshold_lower, pwdata, pstrb,
						WMASK_THR_LO); // R15
					default: nxt_state.spare_word = state_ff.spare_word;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff.clock_channel_config <= RST_CLOCK; // R1
			state_ff.channel_gain_select <= RST_GAIN; // R5
			state_ff.spare_word <= RST_SPARE; // R13
			state_ff.chop_and_detect_config <= RST_CFG; // R8
			state_ff.detect_threshold_upper <= RST_THR_UP;
			state_ff.detect_threshold_lower <= RST_THR_LO;
			state_ff.rdata <= 32'h0000_0000;
			state_ff.err <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ====================================================================
	// bus answers: zero wait state, data registered at the setup edge
	assign pready = 1'b1;
	assign pslverr = access && state_ff.err;
	assign prdata = state_ff.rdata;

	// ====================================================================
	// decoded controls
	logic [15:0] ck;
	logic [15:0] cf;
	logic [15:0] gn;
	assign ck = state_ff.clock_channel_config;
	assign cf = state_ff.chop_and_detect_config;
	assign gn = state_ff.channel_gain_select;

	assign chan_enable = ck[CLK_EN_LSB +: 4]; // R2
	always_comb begin
		case (ck[CLK_OSR_LSB +: 3])
			3'h7: oversampling_ratio = OSR_TOP; // R3
			default: oversampling_ratio = 15'h0080 << ck[CLK_OSR_LSB +: 3]; // R3
		endcase
	end
	always_comb begin
		case (ck[CLK_PWR_LSB +: 2])
			2'h0: power_mode_sel = ACR_PWR_VLOW; // R4
			2'h1: power_mode_sel = ACR_PWR_LOW; // R4
			default: power_mode_sel = ACR_PWR_HIRES; // R4
		endcase
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			chan_gain[i] = pow2_8(gn[i*GAIN_STRIDE +: 3]); // R6 R7
		end
	end
	assign chop_enable = cf[CFG_CHOP_BIT]; // R10
	assign chop_settle_cycles = 17'h00002 << cf[CFG_DLY_LSB +: 4]; // R9
	assign detect_all_channels = cf[CFG_ALL_BIT]; // R11
	assign detect_hit_count = pow2_8(cf[CFG_NUM_LSB +: 3]); // R12
	assign detect_window_length = window_len(cf[CFG_LEN_LSB +: 3]); // R14
	assign detect_mode_enable = cf[CFG_DET_BIT]; // R14
	assign detect_threshold = {state_ff.detect_threshold_upper,
		state_ff.detect_threshold_lower[THR_LO_LSB +: 8]}; // R15
	assign dc_block_sel = state_ff.detect_threshold_lower[THR_DCB_LSB +: 4];
endmodule
`default_nettype wire

// ### sim/acr_regbank_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acr_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [acr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [3:0] chan_enable,
	input wire logic [14:0] oversampling_ratio,
	input wire logic [1:0] power_mode_sel,
	input wire logic [3:0][7:0] chan_gain,
	input wire logic chop_enable,
	input wire logic [16:0] chop_settle_cycles,
	input wire logic [7:0] detect_hit_count
);
	import acr_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	assign wr = psel && penable && pwrite;
	a_chan_en_load: assert property (wr && paddr == 12'h00C && pstrb[1] |=>
		chan_enable == $past(pwdata[11:8])) else $error("channel enable wrong");
	a_power_decode: assert property (wr && paddr == 12'h00C && pstrb[0] |=>
		power_mode_sel == ($past(pwdata[1]) ? 2'h2 : $past(pwdata[1:0])))
		else $error("power mode wrong");
	a_osr_decode: assert property (wr && paddr == 12'h00C && pstrb[0] |=>
		oversampling_ratio == ($past(pwdata[4:2]) == 3'h7 ? 15'h3F80 :
		15'h80 << $past(pwdata[4:2]))) else $error("ratio wrong");
	a_gain_decode: assert property (wr && paddr == 12'h010 && pstrb[1] |=>
		chan_gain[3] == 8'h01 << $past(pwdata[14:12])) else $error("gain wrong");
	a_chop_decode: assert property (wr && paddr == 12'h018 && pstrb[1] |=>
		chop_settle_cycles == 17'h2 << $past(pwdata[12:9]) &&
		chop_enable == $past(pwdata[8])) else $error("chop fields wrong");
	a_hit_decode: assert property (wr && paddr == 12'h018 && pstrb[0] |=>
		detect_hit_count == 8'h01 << $past(pwdata[6:4])) else $error("hits wrong");
	a_clk_top_zero: assert property (psel && penable && paddr == 12'h00C |->
		prdata[31:12] == 20'h0) else $error("clock top bits set");
	a_unmapped_err: assert property (psel && penable && paddr == 12'h000 |->
		pslverr && prdata == 32'h0) else $error("unmapped not refused");
	a_spare_inert: assert property (wr && paddr == 12'h014 |=>
		$stable(chan_enable) && $stable(chan_gain)) else $error("spare has effect");
endmodule
bind acr_regbank acr_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .chan_enable(chan_enable),
	.oversampling_ratio(oversampling_ratio), .power_mode_sel(power_mode_sel),
	.chan_gain(chan_gain), .chop_enable(chop_enable),
	.chop_settle_cycles(chop_settle_cycles), .detect_hit_count(detect_hit_count));
`default_nettype wire

// ### sim/tb_adc_config_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_config_register_bank;
	import acr_pkg::*;
	typedef struct packed {
		logic [11:0] a;
		logic [15:0] d;
		logic [15:0] e;
	} acr_row_t;
	localparam acr_row_t ROWS [6] = '{'{12'h00C, 16'hFFFF, 16'h0FFF},
		'{12'h00C, 16'h0001, 16'h0001}, '{12'h010, 16'hF531, 16'hF531},
		'{12'h014, 16'hA5A5, 16'hA5A5}, '{12'h018, 16'hFFFF, 16'hFFFF},
		'{12'h000, 16'h1234, 16'h0000}};
	localparam logic [15:0] RSTV [4] = '{16'h0F0E, 16'h0, 16'h0, 16'h0600};
	localparam logic [11:0] WLEN [8] = '{12'h080, 12'h100, 12'h200,
		12'h300, 12'h500, 12'h700, 12'hA00, 12'hE00};
	logic detect_mode_enable, detect_all_channels;
	logic [11:0] detect_window_length;
	logic [23:0] detect_threshold;
	logic [3:0] dc_block_sel;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, chan_enable;
	logic [14:0] oversampling_ratio;
	logic [1:0] power_mode_sel;
	logic [3:0][7:0] chan_gain;
	int num_errors, checks;
	acr_regbank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chan_enable(chan_enable), .oversampling_ratio(oversampling_ratio),
		.power_mode_sel(power_mode_sel), .chan_gain(chan_gain), .chop_enable(),
		.chop_settle_cycles(), .detect_mode_enable(detect_mode_enable),
		.detect_all_channels(detect_all_channels), .detect_hit_count(),
		.detect_window_length(detect_window_length),
		.detect_threshold(detect_threshold), .dc_block_sel(dc_block_sel));
	task automatic end_sim;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [15:0] d, input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			end_sim();
		end
		@(posedge pclk);
	endtask
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		num_errors = 0;
		checks = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ROWS[k]) begin
			apb(1'b1, ROWS[k].a, ROWS[k].d, 4'h3);
			apb(1'b0, ROWS[k].a, 16'h0, 4'h0);
			chk(rd, {16'h0, ROWS[k].e});
		end
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 12'h00C, {8'h0F, 3'h0, i[2:0], i[1:0]}, 4'h3);
			apb(1'b1, 12'h010, {4{1'b0, i[2:0]}}, 4'h3);
			apb(1'b1, 12'h018, {4'h0, i[2:0], i[0], i[0], i[2:0], i[2:0],
				i[0]}, 4'h3);
			chk(oversampling_ratio, i == 7 ? 16256 : 128 << i);
			chk(chan_gain[2], 8'h01 << i);
			chk(power_mode_sel, i[1] ? 2'h2 : {1'b0, i[0]});
			chk(detect_window_length, WLEN[i]);
			chk(detect_mode_enable, i[0]);
			chk(detect_all_channels, i[0]);
		end
		apb(1'b1, 12'h01C, 16'hBEEF, 4'h3);
		apb(1'b1, 12'h020, 16'hA5F3, 4'h3);
		chk(detect_threshold, 24'hBEEFA5);
		chk(dc_block_sel, 4'h3);
		apb(1'b0, 12'h020, 16'h0, 4'h0);
		chk(rd, 32'hA503);
		apb(1'b1, 12'h010, 16'hFFFF, 4'h1);
		apb(1'b0, 12'h010, 16'h0, 4'h0);
		chk(rd, 32'h77FF);
		apb(1'b1, 12'h00D, 16'h0000, 4'h3);
		chk(err, 1'b1);
		apb(1'b0, 12'h024, 16'h0, 4'h0);
		chk(err, 1'b1);
		apb(1'b0, 12'h00C, 16'h0, 4'h0);
		chk(rd, 32'h0F1F);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(chan_enable, 4'hF);
		chk(power_mode_sel, 2'h2);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'h00C + 12'(4 * i), 16'h0, 4'h0);
			chk(rd, RSTV[i]);
		end
		end_sim();
	end
endmodule
`default_nettype wire
